/* File: hw/dtp_defines.svh */
// constants of the duty/tone port output block: offsets, fields, resets
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DTP_OFF_CTRL  32'h0000_0000
`define DTP_OFF_PDATA 32'h0000_0004
`define DTP_OFF_SYS   32'h0000_0008
`define DTP_OFF_FCNT  32'h0000_000C
`define DTP_OFF_STAT  32'h0000_0010

// ----------------------------------------
// field positions
// ----------------------------------------
`define DTP_CTRL_SEL   0
`define DTP_CTRL_MLO   1
`define DTP_CTRL_MHI   2
`define DTP_CTRL_LATCH 3
`define DTP_SYS_STOP   0
`define DTP_SYS_CE     1
`define DTP_SYS_HALT   2
`define DTP_STAT_PIN   0
`define DTP_STAT_FREQ  1
`define DTP_STAT_CNT   8
`define DTP_TONE_BIT   5

// ----------------------------------------
// reset values
// ----------------------------------------
`define DTP_RST_MODE  2'h0
`define DTP_RST_LATCH 1'h0
`define DTP_RST_PDATA 6'h00
`define DTP_RST_CNT   6'h00

`endif

/* File: hw/dtp_pkg.sv */
// types of the duty/tone port output block
// assumes dtp_defines.svh is reachable on the include path
package dtp_pkg;

  // ----------------------------------------
  // counter owner
  // ----------------------------------------
  typedef enum logic {
    DTP_OWN_PULSE,
    DTP_OWN_FREQ
  } dtp_owner_e;

  // ----------------------------------------
  // whole state of the top module
  // ----------------------------------------
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic        sel_flag;
    logic [1:0]  mode;
    logic        latch;
    logic        ce_hold;
    logic        halt;
    logic [5:0]  pdata;
    logic [5:0]  cnt;
    logic        tone;
    logic        freq_q;
    logic        pin;
  } dtp_state_s;

endpackage

/* File: hw/dtp_wave.sv */
// compare stage turning the shared counter into wave levels
// assumes the caller owns the counter and the tone flip-flop
`timescale 1ns/100ps
module dtp_wave
  import dtp_pkg::*;
(
  input  wire logic [5:0] cnt,
  input  wire logic [4:0] param,
  output logic            duty_level,
  output logic            tone_hit
);

  // ----------------------------------------
  // compare
  // ----------------------------------------
  // duty high while counter below twice the parameter
  always_comb begin
    duty_level = (cnt < {param, 1'b0});
    tone_hit   = (cnt >= {1'b0, param});
  end

endmodule

/* File: hw/dtp_top.sv */
// duty/tone port output with shared 6-bit counter and wishbone registers
// assumes classic wishbone master on clk_sys, freq_in synchronous to clk_sys
`timescale 1ns/100ps
`include "dtp_defines.svh"
module dtp_top
  import dtp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        freq_in,
  output logic             pin_out
);

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  dtp_state_s q;
  dtp_state_s next_q;
  logic       req;
  logic       wr;
  logic       rd;
  logic       duty_level;
  logic       tone_hit;
  logic       wave_level;
  logic       pulse_on;
  dtp_owner_e owner;

  // address match on a word offset
  function automatic logic hit(input logic [31:0] adr, input logic [31:0] off);
    hit = (adr[31:2] == off[31:2]);
  endfunction

  assign req      = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign rd       = req & ~wb_we_i;
  assign pulse_on = (q.mode == 2'h0);
  assign owner    = pulse_on ? DTP_OWN_PULSE : DTP_OWN_FREQ;

  // ----------------------------------------
  // wave compare
  // ----------------------------------------
  dtp_wave u_wave (
    .cnt        (q.cnt),
    .param      (q.pdata[4:0]),
    .duty_level (duty_level),
    .tone_hit   (tone_hit)
  );

  // function bit picks tone or duty
  assign wave_level = q.pdata[`DTP_TONE_BIT] ? q.tone : duty_level;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_q     = q;
    next_q.ack = req;
    next_q.dat = 32'h0000_0000;

    // register reads, unmapped offsets read zero
    if (rd) begin
      if (hit(wb_adr_i, `DTP_OFF_CTRL)) begin
        next_q.dat[`DTP_CTRL_SEL]   = q.sel_flag;
        next_q.dat[`DTP_CTRL_MLO]   = q.mode[0];
        next_q.dat[`DTP_CTRL_MHI]   = q.mode[1];
        next_q.dat[`DTP_CTRL_LATCH] = q.latch;
      end else if (hit(wb_adr_i, `DTP_OFF_PDATA)) begin
        next_q.dat[7:5] = q.pdata[5:3];
        next_q.dat[3:1] = q.pdata[2:0];
      end else if (hit(wb_adr_i, `DTP_OFF_SYS)) begin
        next_q.dat[`DTP_SYS_CE]   = q.ce_hold;
        next_q.dat[`DTP_SYS_HALT] = q.halt;
      end else if (hit(wb_adr_i, `DTP_OFF_FCNT)) begin
        // no count while pulse owns counter
        if (!pulse_on) begin
          next_q.dat[5:0] = q.cnt;
        end
      end else if (hit(wb_adr_i, `DTP_OFF_STAT)) begin
        next_q.dat[`DTP_STAT_PIN]           = q.pin;
        next_q.dat[`DTP_STAT_FREQ]          = (owner == DTP_OWN_FREQ);
        next_q.dat[`DTP_STAT_CNT +: 6]      = q.cnt;
      end
    end

    // register writes; count register writes fall through untouched
    if (wr) begin
      if (hit(wb_adr_i, `DTP_OFF_CTRL)) begin
        next_q.sel_flag = wb_dat_i[`DTP_CTRL_SEL];
        next_q.mode     = {wb_dat_i[`DTP_CTRL_MHI], wb_dat_i[`DTP_CTRL_MLO]};
        next_q.latch    = wb_dat_i[`DTP_CTRL_LATCH];
      end else if (hit(wb_adr_i, `DTP_OFF_PDATA)) begin
        next_q.pdata = {wb_dat_i[7:5], wb_dat_i[3:1]};
      end else if (hit(wb_adr_i, `DTP_OFF_SYS)) begin
        next_q.ce_hold = wb_dat_i[`DTP_SYS_CE];
        next_q.halt    = wb_dat_i[`DTP_SYS_HALT];
        // clock stop clears select, data kept
        if (wb_dat_i[`DTP_SYS_STOP]) begin
          next_q.sel_flag = 1'b0;
        end
      end
    end

    // shared counter, free running in duty mode, restarted on a hit in tone mode
    next_q.freq_q = freq_in;
    if (pulse_on) begin
      if (q.pdata[`DTP_TONE_BIT] && tone_hit) begin
        next_q.cnt  = `DTP_RST_CNT;
        next_q.tone = ~q.tone;
      end else begin
        next_q.cnt = q.cnt + 6'h01;
      end
    end else begin
      if (freq_in && !q.freq_q) begin
        next_q.cnt = q.cnt + 6'h01;
      end
    end

    // pin source
    if (q.halt || q.ce_hold) begin
      // hold during ce reset and halt
      next_q.pin = q.pin;
    end else if (!q.sel_flag) begin
      next_q.pin = q.latch;
    end else if (pulse_on) begin
      // wave starts at once on clear
      next_q.pin = wave_level;
    end else begin
      next_q.pin = q.pin;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // power-on clears select and latch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q          <= '0;
      q.mode     <= `DTP_RST_MODE;
      q.latch    <= `DTP_RST_LATCH;
      q.pdata    <= `DTP_RST_PDATA;
      q.cnt      <= `DTP_RST_CNT;
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign pin_out  = q.pin;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // select is clear right after reset
  a_sel_after_reset: assert property (disable iff (1'b0)
    !rst_n |=> !q.sel_flag)
    else $error("select flag set after reset");

  // general output follows latch
  a_gp_follows_latch: assert property (
    (!q.sel_flag && !q.halt && !q.ce_hold) |=> (pin_out == $past(q.latch)))
    else $error("pin does not follow port latch");

  // generated wave reaches pin
  a_wave_on_pin: assert property (
    (q.sel_flag && pulse_on && !q.halt && !q.ce_hold)
      |=> (pin_out == $past(wave_level)))
    else $error("pin does not carry wave");

  // nonzero mode freezes pin
  a_mode_freeze: assert property (
    (q.sel_flag && !pulse_on && !q.halt && !q.ce_hold) ##1
      (q.sel_flag && !pulse_on) |=> $stable(pin_out))
    else $error("pin moved while mode nonzero");

  // halt and ce hold keep the pin
  a_hold_pin: assert property (
    (q.halt || q.ce_hold) |=> $stable(pin_out))
    else $error("pin moved during hold");

  // clock stop clears select, keeps data
  a_stop_clears: assert property (
    (wr && hit(wb_adr_i, `DTP_OFF_SYS) && wb_dat_i[`DTP_SYS_STOP])
      |=> (!q.sel_flag && $stable(q.pdata)))
    else $error("clock stop did not clear select");

  // data write takes nibble bits 3..1
  a_pdata_load: assert property (
    (wr && hit(wb_adr_i, `DTP_OFF_PDATA))
      |=> (q.pdata == {$past(wb_dat_i[7:5]), $past(wb_dat_i[3:1])}))
    else $error("data register load wrong");

  // count reads zero while pulse owns counter
  a_fcnt_pulse: assert property (
    (rd && hit(wb_adr_i, `DTP_OFF_FCNT) && pulse_on) |=> (wb_dat_o == 32'h0000_0000))
    else $error("count readable during pulse output");

  // counter steps every cycle in duty mode
  a_duty_counts: assert property (
    (pulse_on && !q.pdata[`DTP_TONE_BIT]) |=> (q.cnt == $past(q.cnt) + 6'h01))
    else $error("duty counter not stepping");

  // ack lasts one cycle
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // tone flips and counter restarts on a hit
  a_tone_flip: assert property (
    (pulse_on && q.pdata[`DTP_TONE_BIT] && tone_hit)
      |=> ((q.tone != $past(q.tone)) && (q.cnt == `DTP_RST_CNT)))
    else $error("tone did not flip on hit");

  // duty mode leaves the tone level alone
  a_duty_tone_still: assert property (
    (pulse_on && !q.pdata[`DTP_TONE_BIT]) |=> $stable(q.tone))
    else $error("tone moved in duty mode");

  // data read returns stored bits in place
  a_pdata_read: assert property (
    (rd && hit(wb_adr_i, `DTP_OFF_PDATA))
      |=> (wb_dat_o == {24'h00_0000, $past(q.pdata[5:3]), 1'b0, $past(q.pdata[2:0]), 1'b0}))
    else $error("data read back wrong");

  // count register writes change nothing
  a_fcnt_write: assert property (
    (wr && hit(wb_adr_i, `DTP_OFF_FCNT))
      |=> ($stable(q.sel_flag) && $stable(q.mode) && $stable(q.pdata)))
    else $error("count register write had an effect");

  // counter moves only on input edges in frequency mode
  a_freq_still: assert property (
    (!pulse_on && !(freq_in && !q.freq_q)) |=> $stable(q.cnt))
    else $error("counter disturbed in frequency mode");

  // each input rising edge steps the counter in frequency mode
  a_freq_step: assert property (
    (!pulse_on && freq_in && !q.freq_q) |=> (q.cnt == $past(q.cnt) + 6'h01))
    else $error("frequency edge not counted");

  // control write loads select, mode and latch
  a_ctrl_load: assert property (
    (wr && hit(wb_adr_i, `DTP_OFF_CTRL))
      |=> ((q.sel_flag == $past(wb_dat_i[`DTP_CTRL_SEL]))
        && (q.mode == {$past(wb_dat_i[`DTP_CTRL_MHI]), $past(wb_dat_i[`DTP_CTRL_MLO])})
        && (q.latch == $past(wb_dat_i[`DTP_CTRL_LATCH]))))
    else $error("control write not loaded");

  // system write loads ce hold and halt
  a_sys_load: assert property (
    (wr && hit(wb_adr_i, `DTP_OFF_SYS))
      |=> ((q.ce_hold == $past(wb_dat_i[`DTP_SYS_CE]))
        && (q.halt == $past(wb_dat_i[`DTP_SYS_HALT]))))
    else $error("system write not loaded");

  // writes without the low byte select are dropped
  a_sel_gate: assert property (
    (req && wb_we_i && !wb_sel_i[0])
      |=> ($stable(q.sel_flag) && $stable(q.mode) && $stable(q.pdata)))
    else $error("write taken without byte select");

  // every taken request is answered next cycle
  a_ack_answer: assert property (
    req |=> wb_ack_o)
    else $error("request not acknowledged");

  // read data is zero outside the ack cycle
  a_dat_idle: assert property (
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data not zero while idle");

  // reset leaves bus, pin, mode and counter at rest
  a_reset_state: assert property (disable iff (1'b0)
    !rst_n |=> (!wb_ack_o && !pin_out && (q.mode == `DTP_RST_MODE)
      && (q.cnt == `DTP_RST_CNT)))
    else $error("state not at rest after reset");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_duty_rise:  cover property (q.sel_flag && pulse_on && $rose(pin_out));
  c_tone_flip:  cover property (q.pdata[`DTP_TONE_BIT] && $changed(q.tone));
  c_freeze:     cover property (q.sel_flag && $changed(q.mode) && !pulse_on);
  c_stop:       cover property ($fell(q.sel_flag) && pulse_on);
  c_freq_edge:  cover property (!pulse_on && freq_in && !q.freq_q);

endmodule

/* File: sim/test_dtp_top.sv */
// self-checking testbench for the duty/tone port output block
// assumes dtp_top, dtp_pkg and dtp_defines.svh are compiled before it
`timescale 1ns/100ps
`include "dtp_defines.svh"
module test_dtp_top
  import dtp_pkg::*;
;
  logic        clk_sys  = 1'b0;
  logic        rst_n    = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        freq_in  = 1'b0;
  logic        pin_out;
  logic [31:0] q;
  logic [31:0] c0;
  int          miscompares = 0;
  int          compares    = 0;
  int          hi;
  int          tg;

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  dtp_top u_dtp_top (
    .clk_sys (clk_sys),  .rst_n    (rst_n),    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i  (wb_we_i),  .wb_adr_i (wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i (wb_dat_i), .wb_dat_o (wb_dat_o),
    .wb_ack_o(wb_ack_o), .freq_in  (freq_in),  .pin_out  (pin_out)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // print counts and verdict, then stop
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int i;
    i = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i >= 20) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // count high cycles and level changes of the pin over n cycles
  task automatic watch(input int n);
    logic p;
    repeat (3) @(posedge clk_sys);
    hi = 0;
    tg = 0;
    p  = pin_out;
    repeat (n) begin
      @(posedge clk_sys);
      hi += int'(pin_out === 1'b1);
      tg += int'(pin_out !== p);
      p  = pin_out;
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(0, `DTP_OFF_CTRL, 32'h0, q); chk(q, 32'h0);
    wb(0, `DTP_OFF_STAT, 32'h0, q); chk(q & 32'h3, 32'h0);
    wb(0, `DTP_OFF_PDATA, 32'h0, q); chk(q, 32'h0);
    wb(1, 32'h20, 32'hFF, q);
    wb(0, 32'h20, 32'h0, q); chk(q, 32'h0);
    $display("test reset done");
    // duty 10 of 64, buffer bits 4 and 0 dropped
    wb(1, `DTP_OFF_PDATA, 32'h1B, q);
    wb(1, `DTP_OFF_CTRL, 32'h1, q);
    watch(64); chk(32'(hi), 32'hA);
    // tone, half period 10
    wb(1, `DTP_OFF_PDATA, 32'hA2, q);
    watch(80); chk(32'(tg), 32'h8);
    $display("test wave done");
    // nonzero mode freezes the pin
    wb(1, `DTP_OFF_CTRL, 32'h3, q);
    watch(30); chk(32'(tg), 32'h0);
    wb(0, `DTP_OFF_STAT, 32'h0, q); chk(q & 32'h2, 32'h2);
    wb(0, `DTP_OFF_FCNT, 32'h0, c0);
    wb(1, `DTP_OFF_FCNT, 32'h3F, q);
    wb(1, `DTP_OFF_PDATA, 32'h0A, q);
    wb(0, `DTP_OFF_PDATA, 32'h0, q); chk(q, 32'h0A);
    // a write without the low byte select is dropped
    wb_sel_i <= 4'hE;
    wb(1, `DTP_OFF_PDATA, 32'h00, q);
    wb_sel_i <= 4'hF;
    wb(0, `DTP_OFF_PDATA, 32'h0, q); chk(q, 32'h0A);
    repeat (5) begin
      @(posedge clk_sys);
      freq_in <= 1'b1;
      @(posedge clk_sys);
      freq_in <= 1'b0;
    end
    wb(0, `DTP_OFF_FCNT, 32'h0, q); chk(q, (c0 + 32'h5) & 32'h3F);
    // clearing the mode starts the programmed duty at once
    wb(1, `DTP_OFF_CTRL, 32'h1, q);
    watch(64); chk(32'(hi), 32'hA);
    wb(1, `DTP_OFF_FCNT, 32'h3F, q);
    wb(0, `DTP_OFF_FCNT, 32'h0, q); chk(q, 32'h0);
    $display("test counter done");
    // clock stop clears select, data kept
    wb(1, `DTP_OFF_SYS, 32'h1, q);
    wb(0, `DTP_OFF_CTRL, 32'h0, q); chk(q, 32'h0);
    watch(10); chk(32'(hi), 32'h0);
    wb(1, `DTP_OFF_CTRL, 32'h1, q);
    watch(64); chk(32'(hi), 32'hA);
    // ce hold then halt keep the pin still
    for (int k = 2; k <= 4; k += 2) begin
      wb(1, `DTP_OFF_SYS, 32'(k), q);
      watch(70); chk(32'(tg), 32'h0);
    end
    wb(1, `DTP_OFF_SYS, 32'h0, q);
    // select clear routes the port latch
    wb(1, `DTP_OFF_CTRL, 32'h8, q);
    watch(10); chk(32'(hi), 32'hA);
    wb(1, `DTP_OFF_CTRL, 32'h0, q);
    watch(10); chk(32'(hi), 32'h0);
    $display("test hold done");
    wrap_up();
  end
endmodule
